// >>> core/pas_pkg.sv
// shared constants for the port-a and pin steering block
package pas_pkg;
	// avalon word byte offsets
	localparam logic [7:0] PAS_OFS_PIN_VALUE = 8'h00; // read pins, write latch
	localparam logic [7:0] PAS_OFS_LATCH = 8'h04; // output latch
	localparam logic [7:0] PAS_OFS_DIRECTION = 8'h08; // direction bits
	localparam logic [7:0] PAS_OFS_ANALOG = 8'h0C; // analog select bits
	localparam logic [7:0] PAS_OFS_STEER = 8'h10; // pin steering control
	localparam logic [7:0] PAS_OFS_CONFIG = 8'h14; // configuration word bits

	// reset values
	localparam logic [7:0] PAS_RST_LATCH = 8'h00;
	localparam logic [7:0] PAS_RST_DIRECTION = 8'hFF; // all inputs
	localparam logic [7:0] PAS_RST_ANALOG = 8'h2F; // analog on every implemented bit
	localparam logic [7:0] PAS_ANALOG_IMPL = 8'h2F; // bits 5 and 3..0 exist
	localparam logic [7:0] PAS_RST_STEER = 8'h00;
	localparam logic [2:0] PAS_RST_CONFIG = 3'h0;
	localparam logic [31:0] PAS_RDATA_ZERO = 32'h0000_0000;

	// configuration word field positions
	localparam int PAS_CFG_OSC_OUT = 0; // crystal drive on bit 6
	localparam int PAS_CFG_CLK_OUT = 1; // divided clock on bit 6
	localparam int PAS_CFG_OSC_IN = 2; // crystal clock input on bit 7

	// steering register field positions
	localparam int PAS_STEER_CH1_PWM_B = 0;
	localparam int PAS_STEER_CH1_PWM_C = 1;
	localparam int PAS_STEER_CH2_CAPCMP = 2;
	localparam int PAS_STEER_CH2_PWM_B = 3;
	localparam int PAS_STEER_CH2_PWM_C = 4;
	localparam int PAS_STEER_CH2_PWM_D = 5;
	localparam int PAS_STEER_CH3_PWM_B = 6;
	localparam int PAS_STEER_CH3_PWM_C = 7;

	// sizes
	localparam int PAS_PORT_W = 8;
	localparam int PAS_FUNC_N = 8;
	localparam int PAS_ALT_N = 16; // two candidate pins per function

	// bus handshake states, one-hot
	typedef enum logic [1:0] {
		PAS_IDLE = 2'b01,
		PAS_ACK = 2'b10
	} pas_bus_st_t;
endpackage

// >>> core/pas_port_a.sv
// Overview of operation
// - eight-bit steering register, read/write, resets zero
// - steering leaves direction; overrides follow function
// - unselected pin keeps its ordinary behaviour
// - direction one disables driver, pin input
// - direction zero drives pin from latch
// - port read gives pins, write sets latch
// - port write samples pins, modifies, stores latch
// - latch write equals port write; reads latch
// - direction still governs drivers on analog pins
// - analog select reads zero, enables analog
// - analog select leaves digital outputs untouched
// - analog select bits reset to analog
// - highest priority enabled source owns the pin
// - analog inputs live; outputs still by priority
// - bits 0-5: lcd segment, then port
// - bit 6: crystal, clock, segment, then port
// - bit 7: crystal input, segment, then port
// - eight bidirectional bits with direction, latch, read
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
module pas_port_a (
	input wire logic clk_sys,
	input wire logic rst_b,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// port a pins
	input wire logic [7:0] pin_value_a_pin_in,
	output logic [7:0] pin_value_a_pin_out,
	output logic [7:0] pin_value_a_pin_oe,
	output logic [7:0] pin_value_a_analog_en,
	output logic [7:0] pin_value_a_digital_in,
	// peripheral sources on port a
	input wire logic [7:0] lcd_segment_line_val,
	input wire logic [7:0] lcd_segment_line_en,
	input wire logic crystal_drive_out,
	input wire logic divided_clock_out,
	output logic crystal_clock_in,
	// steered functions
	input wire logic [7:0] steer_fn_val,
	input wire logic [7:0] steer_fn_en,
	output logic ch2_capture_in,
	// candidate pins of the steered functions
	input wire logic [15:0] alt_pin_in,
	input wire logic [15:0] alt_gp_val,
	input wire logic [15:0] alt_gp_en,
	output logic [15:0] alt_pin_out,
	output logic [15:0] alt_pin_oe
);
	// software visible state
	logic [7:0] latch_r; // output latch
	logic [7:0] direction_r; // one means input
	logic [7:0] analog_r; // analog select
	logic [7:0] steer_r; // pin steering control
	logic [2:0] config_r; // configuration word bits

	// bus handshake
	// one access costs two cycles; no request is ever left outstanding
	pas_pkg::pas_bus_st_t bus_st_r; // handshake state
	pas_pkg::pas_bus_st_t bus_st_nxt; // next handshake state
	logic waitrequest_r; // registered waitrequest
	logic [31:0] readdata_r; // registered read data
	logic bus_req; // read or write pending
	logic wr_take; // write takes effect this edge
	logic be_low; // low byte lane enabled

	// pin side
	logic [7:0] pin_read; // digital view of the pins
	logic [7:0] prio_val; // priority mux level
	logic [7:0] prio_en; // priority mux enable
	logic [7:0] latch_nxt; // value stored on a port write
	logic [31:0] rd_mux; // read data source
	logic [7:0] pin_out_r; // registered port a level
	logic [7:0] pin_oe_r; // registered port a enable
	logic [7:0] analog_en_r; // registered analog connect
	logic [7:0] digital_in_r; // registered digital read
	logic osc_in_r; // registered crystal input
	logic [15:0] alt_out_r; // registered candidate level
	logic [15:0] alt_oe_r; // registered candidate enable
	logic cap_r; // registered capture input

	// candidate pad levels enter the mux unregistered; only its outputs are stored
	pas_steer_if sif ();

	// steering mux connections; direction state is never touched here
	assign sif.pick = steer_r;
	assign sif.fn_val = steer_fn_val;
	assign sif.fn_en = steer_fn_en;
	assign sif.alt_in = alt_pin_in;
	assign sif.gp_val = alt_gp_val;
	assign sif.gp_en = alt_gp_en;

	pas_steer u_steer (
		.sif(sif)
	);

	assign bus_req = avs_read | avs_write;
	assign wr_take = avs_write & (bus_st_r == pas_pkg::PAS_ACK);
	assign be_low = avs_byteenable[0];

	// handshake: one wait cycle, then a single acknowledge cycle
	// the request edge only loads read data; the acknowledge edge commits writes
	always_comb begin
		bus_st_nxt = bus_st_r;
		case (bus_st_r)
			pas_pkg::PAS_IDLE: begin
				// request seen, answer next cycle
				if (bus_req) begin
					bus_st_nxt = pas_pkg::PAS_ACK;
				end
			end
			pas_pkg::PAS_ACK: begin
				// master releases after this edge
				bus_st_nxt = pas_pkg::PAS_IDLE;
			end
			default: begin
				bus_st_nxt = pas_pkg::PAS_IDLE;
			end
		endcase
	end

	// handshake state register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			bus_st_r <= pas_pkg::PAS_IDLE;
		end else begin
			bus_st_r <= bus_st_nxt;
		end
	end

	// waitrequest low only in the acknowledge cycle
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			waitrequest_r <= 1'b1;
		end else begin
			waitrequest_r <= (bus_st_nxt != pas_pkg::PAS_ACK);
		end
	end

	// digital read: analog pins always read zero
	assign pin_read = pin_value_a_pin_in & ~analog_r;

	// register read mux; unmapped offsets read zero
	always_comb begin
		rd_mux = pas_pkg::PAS_RDATA_ZERO;
		case (avs_address)
			pas_pkg::PAS_OFS_PIN_VALUE: begin
				rd_mux = {24'h000000, pin_read};
			end
			pas_pkg::PAS_OFS_LATCH: begin
				rd_mux = {24'h000000, latch_r};
			end
			pas_pkg::PAS_OFS_DIRECTION: begin
				rd_mux = {24'h000000, direction_r};
			end
			pas_pkg::PAS_OFS_ANALOG: begin
				rd_mux = {24'h000000, analog_r & pas_pkg::PAS_ANALOG_IMPL};
			end
			pas_pkg::PAS_OFS_STEER: begin
				rd_mux = {24'h000000, steer_r};
			end
			pas_pkg::PAS_OFS_CONFIG: begin
				rd_mux = {29'h00000000, config_r};
			end
			default: begin
				rd_mux = pas_pkg::PAS_RDATA_ZERO;
			end
		endcase
	end

	// read data loaded on the request edge, held until the next read
	// pins are sampled one cycle before the acknowledge edge
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			readdata_r <= pas_pkg::PAS_RDATA_ZERO;
		end else if (avs_read && bus_st_r == pas_pkg::PAS_IDLE) begin
			readdata_r <= rd_mux;
		end
	end

	// port write: pins sampled, written lane replaces them, whole byte stored;
	// with the low lane off the sampled pins alone land in the latch
	// hazard: analog pins read zero, so such a write clears their latch bits
	assign latch_nxt = be_low ? avs_writedata[7:0] : pin_read;

	// output latch, written through either the pin or the latch offset
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			latch_r <= pas_pkg::PAS_RST_LATCH;
		end else if (wr_take && (avs_address == pas_pkg::PAS_OFS_PIN_VALUE ||
			avs_address == pas_pkg::PAS_OFS_LATCH)) begin
			latch_r <= latch_nxt;
		end
	end

	// direction register; steering writes never reach it
	// reset leaves every pin an input so the latch drives no pin early; an enabled segment line on any of bits 0-7 still drives
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			direction_r <= pas_pkg::PAS_RST_DIRECTION;
		end else if (wr_take && be_low && avs_address == pas_pkg::PAS_OFS_DIRECTION) begin
			direction_r <= avs_writedata[7:0];
		end
	end

	// analog select, only implemented bits hold a value
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			analog_r <= pas_pkg::PAS_RST_ANALOG;
		end else if (wr_take && be_low && avs_address == pas_pkg::PAS_OFS_ANALOG) begin
			analog_r <= avs_writedata[7:0] & pas_pkg::PAS_ANALOG_IMPL;
		end
	end

	// pin steering control
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			steer_r <= pas_pkg::PAS_RST_STEER;
		end else if (wr_take && be_low && avs_address == pas_pkg::PAS_OFS_STEER) begin
			steer_r <= avs_writedata[7:0];
		end
	end

	// configuration bits standing in for the configuration word
	// only three bits exist; higher write data is dropped
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			config_r <= pas_pkg::PAS_RST_CONFIG;
		end else if (wr_take && be_low && avs_address == pas_pkg::PAS_OFS_CONFIG) begin
			config_r <= avs_writedata[2:0];
		end
	end

	// output priority per pin; analog select plays no part here
	always_comb begin
		prio_val = latch_r;
		prio_en = ~direction_r;
		// bits 0-5: segment line above the port bit
		// a segment wins even over a pin set as input
		for (int i = 0; i < 6; i++) begin
			if (lcd_segment_line_en[i]) begin
				prio_val[i] = lcd_segment_line_val[i];
				prio_en[i] = 1'b1;
			end
		end
		// bit 6: crystal drive, divided clock, segment, port
		if (config_r[pas_pkg::PAS_CFG_OSC_OUT]) begin
			prio_val[6] = crystal_drive_out;
			prio_en[6] = 1'b1;
		end else if (config_r[pas_pkg::PAS_CFG_CLK_OUT]) begin
			prio_val[6] = divided_clock_out;
			prio_en[6] = 1'b1;
		end else if (lcd_segment_line_en[6]) begin
			prio_val[6] = lcd_segment_line_val[6];
			prio_en[6] = 1'b1;
		end
		// bit 7: crystal input owns the pin and keeps its driver off
		// limitation: as crystal input the pin has no output path at all
		if (config_r[pas_pkg::PAS_CFG_OSC_IN]) begin
			prio_val[7] = 1'b0;
			prio_en[7] = 1'b0;
		end else if (lcd_segment_line_en[7]) begin
			prio_val[7] = lcd_segment_line_val[7];
			prio_en[7] = 1'b1;
		end
	end

	// port a pin drive, registered so outputs are glitch free; costs one cycle
	// reset holds every driver off until the registers settle
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pin_out_r <= 8'h00;
			pin_oe_r <= 8'h00;
		end else begin
			pin_out_r <= prio_val;
			pin_oe_r <= prio_en;
		end
	end

	// analog functions connect whenever analog select is set
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			analog_en_r <= 8'h00;
		end else begin
			analog_en_r <= analog_r;
		end
	end

	// digital input buffer; analog pins already masked to zero
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			digital_in_r <= 8'h00;
		end else begin
			digital_in_r <= pin_read;
		end
	end

	// crystal input taken from bit 7 only when enabled
	// gated so an unused pad cannot toggle the clock input
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			osc_in_r <= 1'b0;
		end else begin
			osc_in_r <= config_r[pas_pkg::PAS_CFG_OSC_IN] & pin_value_a_pin_in[7];
		end
	end

	// steered candidate pins
	// trade-off: one stage keeps moved functions glitch free but adds a cycle
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			alt_out_r <= 16'h0000;
			alt_oe_r <= 16'h0000;
		end else begin
			alt_out_r <= sif.mux_val;
			alt_oe_r <= sif.mux_en;
		end
	end

	// capture input from whichever pin channel two sits on
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cap_r <= 1'b0;
		end else begin
			cap_r <= sif.cap_in;
		end
	end

	// outputs straight from flip-flops
	assign avs_readdata = readdata_r;
	assign avs_waitrequest = waitrequest_r;
	assign pin_value_a_pin_out = pin_out_r;
	assign pin_value_a_pin_oe = pin_oe_r;
	assign pin_value_a_analog_en = analog_en_r;
	assign pin_value_a_digital_in = digital_in_r;
	assign crystal_clock_in = osc_in_r;
	assign ch2_capture_in = cap_r;
	assign alt_pin_out = alt_out_r;
	assign alt_pin_oe = alt_oe_r;
endmodule

// >>> core/pas_steer.sv
// moves each function to one of its two pins; pin 2k is the default, 2k+1 the alternate
module pas_steer (
	pas_steer_if.mux sif
);
	genvar k;
	generate
		for (k = 0; k < pas_pkg::PAS_FUNC_N; k++) begin : g_fn
			// selected pin takes the function, the other keeps its own drive
			always_comb begin
				if (sif.pick[k]) begin
					sif.mux_val[2*k] = sif.gp_val[2*k];
					sif.mux_en[2*k] = sif.gp_en[2*k];
					sif.mux_val[2*k+1] = sif.fn_en[k] ? sif.fn_val[k] : sif.gp_val[2*k+1];
					sif.mux_en[2*k+1] = sif.fn_en[k] | sif.gp_en[2*k+1];
				end else begin
					sif.mux_val[2*k] = sif.fn_en[k] ? sif.fn_val[k] : sif.gp_val[2*k];
					sif.mux_en[2*k] = sif.fn_en[k] | sif.gp_en[2*k];
					sif.mux_val[2*k+1] = sif.gp_val[2*k+1];
					sif.mux_en[2*k+1] = sif.gp_en[2*k+1];
				end
			end
		end
	endgenerate

	// capture input follows the capture/compare output to the same pin
	assign sif.cap_in = sif.pick[pas_pkg::PAS_STEER_CH2_CAPCMP] ?
		sif.alt_in[2*pas_pkg::PAS_STEER_CH2_CAPCMP+1] :
		sif.alt_in[2*pas_pkg::PAS_STEER_CH2_CAPCMP];
endmodule

// >>> core/pas_steer_if.sv
// signals between the top and the steering mux
interface pas_steer_if;
	logic [7:0] pick; // steering register value
	logic [7:0] fn_val; // function output levels
	logic [7:0] fn_en; // function output enables
	logic [15:0] alt_in; // levels seen on the candidate pins
	logic [15:0] gp_val; // ordinary output of each candidate pin
	logic [15:0] gp_en; // ordinary enable of each candidate pin
	logic [15:0] mux_val; // resulting pin level
	logic [15:0] mux_en; // resulting pin enable
	logic cap_in; // channel two capture input

	modport top (output pick, output fn_val, output fn_en, output alt_in,
		output gp_val, output gp_en, input mux_val, input mux_en, input cap_in);
	modport mux (input pick, input fn_val, input fn_en, input alt_in,
		input gp_val, input gp_en, output mux_val, output mux_en, output cap_in);
endinterface

// >>> tb/pas_pin_model.sv
// far side of the port: pad wires plus whatever else hangs on them
module pas_pin_model #(
	parameter int W = 8
) (
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pin_oe,
	input wire logic [W-1:0] ext_lvl,
	output logic [W-1:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// a driven pad reads back its own level; a released one shows the external pattern,
	// which the bench reshuffles each test so a stale value can never pass for a match
	assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule

// >>> tb/pas_port_a_checker.sv
// watches the port-a block at its boundary only
module pas_port_a_checker (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [7:0] pin_value_a_pin_out,
	input wire logic [7:0] pin_value_a_pin_oe,
	input wire logic [7:0] pin_value_a_analog_en,
	input wire logic [7:0] pin_value_a_digital_in,
	input wire logic [7:0] lcd_segment_line_val,
	input wire logic [7:0] lcd_segment_line_en,
	input wire logic crystal_clock_in,
	input wire logic [7:0] steer_fn_en,
	input wire logic ch2_capture_in,
	input wire logic [15:0] alt_pin_in,
	input wire logic [15:0] alt_gp_val,
	input wire logic [15:0] alt_gp_en,
	input wire logic [15:0] alt_pin_out,
	input wire logic [15:0] alt_pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// acknowledge lasts exactly one cycle
	ack_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for two cycles");
	// a pending request is answered in the next cycle
	ack_after_req_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	// only eight data bits exist
	rdata_upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
		else $error("upper read data not zero");
	analog_reads_zero_a: assert property ((pin_value_a_digital_in & pin_value_a_analog_en) == 8'h00)
		else $error("analog pin reads one");
	// analog select comes up set once reset is gone
	analog_reset_a: assert property ($rose(rst_b) |-> ##2 pin_value_a_analog_en == pas_pkg::PAS_RST_ANALOG)
		else $error("analog select not at reset value");
	// pin 7 taken as crystal input never drives
	clkin_no_drive_a: assert property (crystal_clock_in |-> !pin_value_a_pin_oe[7])
		else $error("crystal input pin driven");
	unsteered_gp_a: assert property ($past(rst_b) && $past(steer_fn_en) == 8'h00 |->
		alt_pin_oe == $past(alt_gp_en) && alt_pin_out == $past(alt_gp_val)) else $error("idle pins altered");
	capture_pin_a: assert property ($past(rst_b) |->
		ch2_capture_in == $past(alt_pin_in[4]) || ch2_capture_in == $past(alt_pin_in[5]))
		else $error("capture input from wrong pin");
	// a segment driver wins over the port bit on pins 0 to 5
	for (genvar k = 0; k < 6; k++) begin : g_seg
		segment_owns_pin_a: assert property ($past(rst_b) && $past(lcd_segment_line_en[k]) |->
			pin_value_a_pin_oe[k] && pin_value_a_pin_out[k] == $past(lcd_segment_line_val[k])) else $error("segment lost pin");
	end
	// an enabled steered function lands on one of its two pins
	for (genvar k = 0; k < 8; k++) begin : g_fn
		steered_pair_a: assert property ($past(rst_b) && $past(steer_fn_en[k]) |->
			alt_pin_oe[2*k] || alt_pin_oe[2*k+1]) else $error("steered function not driven");
	end
endmodule

bind pas_port_a pas_port_a_checker pas_port_a_checker_inst (.*);

// >>> tb/tb_top.sv
// random register and pin traffic against computed pin behaviour
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, crystal_clock_in, ch2_capture_in;
	logic [31:0] avs_writedata = 32'h00000000, avs_readdata, rd;
	logic [3:0] avs_byteenable = 4'hF;
	logic [7:0] pin_value_a_pin_in, pin_value_a_pin_out, pin_value_a_pin_oe, pin_value_a_analog_en, pin_value_a_digital_in;
	logic [7:0] lcd_segment_line_val = 8'h00, lcd_segment_line_en = 8'h00;
	logic [7:0] steer_fn_val = 8'h00, steer_fn_en = 8'h00;
	logic crystal_drive_out = 1'b0, divided_clock_out = 1'b0;
	logic [15:0] alt_pin_in, alt_gp_val = 16'h0000, alt_gp_en = 16'h0000, alt_pin_out, alt_pin_oe;
	logic [23:0] ext_lvl = 24'h000000; // level of released pads
	logic [7:0] lat, dir, an, st, lvl; // mirrors of what was written; lvl is the expected pad level
	logic [2:0] cfg;
	logic [15:0] pe;
	logic [31:0] ae;
	int miscompares = 0;
	int num_checks = 0;

	pas_port_a pas_port_a_inst (.*);
	pas_pin_model #(.W(24)) pas_pin_model_inst (.pin_out({alt_pin_out, pin_value_a_pin_out}),
		.pin_oe({alt_pin_oe, pin_value_a_pin_oe}), .ext_lvl(ext_lvl), .pin_in({alt_pin_in, pin_value_a_pin_in}));

	// 20 MHz system clock
	initial begin
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// one avalon access; holds everything until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		// a slave that never answers ends the run
		if (avs_waitrequest !== 1'b0) begin
			miscompares++;
			complete_run();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00, 4'hF);
		check(rd, {24'h000000, exp});
	endtask

	// port pins: {enable, driven level}; crystal output beats clock output on bit 6
	function automatic logic [15:0] port_exp(input logic [7:0] l, d, sv, se, input logic [2:0] c, input logic o, k);
		logic [7:0] v, e;
		e = se | ~d;
		v = (se & sv) | (~se & l);
		if (c[1]) begin
			e[6] = 1'b1;
			v[6] = k;
		end
		if (c[0]) begin
			e[6] = 1'b1;
			v[6] = o;
		end
		if (c[2]) begin
			e[7] = 1'b0;
		end
		return {e, v & e};
	endfunction

	// candidate pins: chosen pin 2k+bit takes the function when it is enabled
	function automatic logic [31:0] alt_exp(input logic [7:0] s, fe, fv, input logic [15:0] gv, ge);
		logic [15:0] v, e;
		int p;
		v = gv;
		e = ge;
		for (int k = 0; k < 8; k++) begin
			p = 2 * k + s[k];
			e[p] = fe[k] | ge[p];
			v[p] = fe[k] ? fv[k] : gv[p];
		end
		return {e, v & e};
	endfunction

	initial begin
		void'($urandom(32'hEE5E1889));
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		rdchk(pas_pkg::PAS_OFS_STEER, 8'h00);
		rdchk(pas_pkg::PAS_OFS_DIRECTION, 8'hFF);
		rdchk(pas_pkg::PAS_OFS_ANALOG, 8'h2F);
		rdchk(8'h18, 8'h00);
		check(pin_value_a_pin_oe, 8'h00);
		check(pin_value_a_analog_en, 8'h2F);
		$display("reset test done");
		// walking one through the steering register
		for (int i = 0; i < 8; i++) begin
			wr(pas_pkg::PAS_OFS_STEER, 8'h01 << i);
			rdchk(pas_pkg::PAS_OFS_STEER, 8'h01 << i);
		end
		for (int i = 0; i < 40; i++) begin
			lat = 8'($urandom);
			dir = (i == 0) ? 8'h00 : 8'($urandom);
			an = (i == 0) ? 8'hFF : 8'($urandom);
			st = 8'($urandom);
			cfg = (i < 8) ? 3'(i) : 3'($urandom);
			wr(i[0] ? pas_pkg::PAS_OFS_LATCH : pas_pkg::PAS_OFS_PIN_VALUE, lat);
			wr(pas_pkg::PAS_OFS_DIRECTION, dir);
			wr(pas_pkg::PAS_OFS_ANALOG, an);
			wr(pas_pkg::PAS_OFS_STEER, st);
			wr(pas_pkg::PAS_OFS_CONFIG, {5'h00, cfg});
			@(posedge clk_sys);
			lcd_segment_line_val <= 8'($urandom);
			lcd_segment_line_en <= (i < 2) ? 8'h00 : 8'($urandom);
			steer_fn_val <= 8'($urandom);
			steer_fn_en <= (i == 1) ? 8'h00 : 8'($urandom);
			alt_gp_val <= 16'($urandom);
			alt_gp_en <= 16'($urandom);
			crystal_drive_out <= 1'($urandom);
			divided_clock_out <= 1'($urandom);
			ext_lvl <= 24'($urandom);
			// registered outputs fed back through the pads need two edges; sample away from the edge
			repeat (2) @(posedge clk_sys);
			@(negedge clk_sys);
			pe = port_exp(lat, dir, lcd_segment_line_val, lcd_segment_line_en, cfg, crystal_drive_out,
				divided_clock_out);
			ae = alt_exp(st, steer_fn_en, steer_fn_val, alt_gp_val, alt_gp_en);
			lvl = pe[7:0] | (ext_lvl[7:0] & ~pe[15:8]);
			check({pin_value_a_pin_oe, pin_value_a_pin_out & pin_value_a_pin_oe}, pe);
			check({alt_pin_oe, alt_pin_out & alt_pin_oe}, ae);
			check(ch2_capture_in, ae[4 + st[2]] | (ext_lvl[12 + st[2]] & ~ae[20 + st[2]]));
			check(crystal_clock_in, cfg[2] & lvl[7]);
			check(pin_value_a_digital_in, lvl & ~(an & 8'h2F));
			check(pin_value_a_analog_en, an & 8'h2F);
			rdchk(pas_pkg::PAS_OFS_PIN_VALUE, lvl & ~(an & 8'h2F));
			rdchk(pas_pkg::PAS_OFS_LATCH, lat);
			rdchk(pas_pkg::PAS_OFS_ANALOG, an & 8'h2F);
			rdchk(pas_pkg::PAS_OFS_STEER, st);
			rdchk(pas_pkg::PAS_OFS_DIRECTION, dir);
			// masked write stores the sampled pin read into the latch
			bus(1'b1, i[1] ? pas_pkg::PAS_OFS_PIN_VALUE : pas_pkg::PAS_OFS_LATCH, 8'h00, 4'hE);
			rdchk(pas_pkg::PAS_OFS_LATCH, lvl & ~(an & 8'h2F));
			$display("pass %0d done", i);
		end
		// second reset in mid-run restores the defaults
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		rdchk(pas_pkg::PAS_OFS_ANALOG, 8'h2F);
		rdchk(pas_pkg::PAS_OFS_STEER, 8'h00);
		rdchk(pas_pkg::PAS_OFS_DIRECTION, 8'hFF);
		$display("second reset test done");
		complete_run();
	end
endmodule
